//--- pkg/adc_seq_pkg.sv
// constants for the conversion sequencer
//
// Operation
// - single mode converts on an internal tick of about 125 ns, 117 to 133; the code ticks every 3 clocks of 50 ns, 150 ns.
// - single mode data available within pipeline plus trigger based delay bound.
// - trigger levels 1,4,8,14 for one input; 2,4,8,12 for two inputs.
// - trigger equal to channel count gives pipeline latency plus n periods.
// - continuous mode first data available comes 7 plus trigger clocks after reset.
// - continuous mode starts a conversion on each conversion clock falling edge.
// - single mode when control bit 1 is one.
// - start falling edge holds all selected inputs together and starts conversion.
// - single mode timed by oscillator, continuous by external conversion clock.
// - data available fires once written samples reach the trigger level.
// - each result is 12 bits from four 1-bit and four 2-bit stages.
// - pipeline takes a new sample while seven stages hold older samples; the code has seven stages, six holding older samples.
// - external reference limits used only when reference select is external.
// - host programs selected inputs and single-ended or differential use.
// - continuous mode when bit 1 is zero; one value per clock rising edge.
// - data available is an active low pulse per trigger.
package adc_seq_pkg;
   // register map (word addresses, byte address is four times)
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;
   localparam logic [1:0] ADDR_COUNT = 2'h2;
   // control field positions
   localparam int BIT_FIFO_RST = 0;
   localparam int BIT_SINGLE = 1;
   localparam int BIT_TRIG_LO = 2;
   localparam int BIT_TRIG_HI = 3;
   localparam int BIT_CH0 = 4;
   localparam int BIT_CH1 = 5;
   localparam int BIT_DIFF = 6;
   localparam int BIT_EXTREF = 7;
   localparam logic [7:0] CTRL_RESET = 8'h02;
   // timing in ns and clock
   localparam int CLK_NS = 50;
   localparam int OSC_NS = 125;
   localparam int OSC_MIN_NS = 117;
   localparam int OSC_MAX_NS = 133;
   // tick period rounds the nominal to the nearest whole clock; min/max are not applied
   localparam int OSC_CYC = (OSC_NS + CLK_NS / 2) / CLK_NS;
   localparam int PIPE_STAGES = 8;
   localparam int PIPE_LAT = 7;
   // single mode taps the pipeline early so a result leaves on the 4th tick
   localparam int SGL_LAT = 3;
   localparam int RES_BITS = 12;
   localparam int PULSE_CYC = 1;
   typedef enum logic [1:0] {ST_IDLE, ST_CONV} conv_state_t;
endpackage

//--- core/adc_trigger_level.sv
// trigger level decode from selects and channel count
`timescale 1ns/1ps
module adc_trigger_level (
   input wire logic i_trig_lo,
   input wire logic i_trig_hi,
   input wire logic i_two_ch,
   output logic [3:0] o_level
);
   // level table per channel count
   always_comb begin
      unique case ({i_trig_hi, i_trig_lo})
         2'b00: o_level = i_two_ch ? 4'hC : 4'hE;
         2'b01: o_level = 4'h4;
         2'b10: o_level = 4'h8;
         2'b11: o_level = i_two_ch ? 4'h2 : 4'h1;
      endcase
   end
endmodule // adc_trigger_level

//--- core/adc_conversion_sequencer.sv
// conversion sequencer with avalon register slave
//
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ps
module adc_conversion_sequencer #(
   parameter int OSC_CYCLES = adc_seq_pkg::OSC_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [1:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire logic i_conversion_start_pulse,
   input wire logic i_external_conversion_clock,
   input wire logic [11:0] i_sample_ch0,
   input wire logic [11:0] i_sample_ch1,
   output logic o_hold,
   output logic o_data_available_out_n,
   output logic o_wr_valid,
   output logic [11:0] o_wr_data,
   output logic o_wr_channel,
   output logic o_use_ext_ref,
   output logic o_differential,
   output logic [1:0] o_ch_enable,
   output logic o_osc_run
);
   localparam int PIPE_W = adc_seq_pkg::PIPE_LAT;
   localparam int SGL_W = adc_seq_pkg::SGL_LAT;

   // tick counter is two bits; at 50 ns the nearest tick is three clocks
   if (OSC_CYCLES < 1 || OSC_CYCLES > 4 ||
       SGL_W < 2 || SGL_W > PIPE_W) begin : g_bad_param
      $error("oscillator period or pipeline tap out of range");
   end

   logic [7:0] ctrl;
   logic [2:0] start_sync;
   logic [2:0] cclk_sync;
   logic start_lvl;
   logic cclk_lvl;
   logic start_fall;
   logic cclk_fall;
   logic cclk_rise;
   logic single_mode;
   logic two_ch;
   logic [3:0] level;
   logic [3:0] fill;
   logic first_done;
   logic [11:0] held0;
   logic [11:0] held1;
   logic push_v;
   logic [1:0] osc_cnt;
   logic osc_tick;
   adc_seq_pkg::conv_state_t state;
   logic [1:0] ch_left;
   logic [PIPE_W-1:0] pipe_v;
   logic [PIPE_W-1:0] pipe_c;
   logic [11:0] pipe_d [PIPE_W];
   logic conv_step;
   logic in_chan;
   logic [11:0] in_data;
   logic fifo_rst;
   logic [1:0] wait_cnt;

   assign single_mode = ctrl[adc_seq_pkg::BIT_SINGLE];
   assign two_ch = ctrl[adc_seq_pkg::BIT_CH0] & ctrl[adc_seq_pkg::BIT_CH1];
   assign fifo_rst = i_write && !o_waitrequest &&
      i_address == adc_seq_pkg::ADDR_CTRL &&
      i_writedata[adc_seq_pkg::BIT_FIFO_RST];

   // trigger level lookup
   adc_trigger_level u_level (
      .i_trig_lo(ctrl[adc_seq_pkg::BIT_TRIG_LO]),
      .i_trig_hi(ctrl[adc_seq_pkg::BIT_TRIG_HI]),
      .i_two_ch(two_ch),
      .o_level(level)
   );

   // pin synchronisers, change counts when stages two and three agree
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         start_sync <= 3'h7;
         cclk_sync <= 3'h0;
         start_lvl <= 1'b1;
         cclk_lvl <= 1'b0;
      end else begin
         start_sync <= {start_sync[1:0], i_conversion_start_pulse};
         cclk_sync <= {cclk_sync[1:0], i_external_conversion_clock};
         if (start_sync[1] == start_sync[2])
            start_lvl <= start_sync[2];
         if (cclk_sync[1] == cclk_sync[2])
            cclk_lvl <= cclk_sync[2];
      end
   end
   assign start_fall = start_lvl && start_sync[1] == start_sync[2] &&
      !start_sync[2];
   assign cclk_fall = cclk_lvl && cclk_sync[1] == cclk_sync[2] &&
      !cclk_sync[2];
   assign cclk_rise = !cclk_lvl && cclk_sync[1] == cclk_sync[2] &&
      cclk_sync[2];

   // avalon slave: one wait cycle then answer
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_waitrequest <= 1'b1;
         wait_cnt <= 2'h0;
      end else if ((i_read || i_write) && o_waitrequest &&
                   wait_cnt == 2'h0) begin
         o_waitrequest <= 1'b0;
         wait_cnt <= 2'h1;
      end else begin
         o_waitrequest <= 1'b1;
         wait_cnt <= 2'h0;
      end
   end

   // control register, reset bit is self clearing
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl <= adc_seq_pkg::CTRL_RESET;
      end else if (i_write && !o_waitrequest &&
                   i_address == adc_seq_pkg::ADDR_CTRL) begin
         ctrl <= i_writedata[7:0] & 8'hFE;
      end
   end

   // read data mux, unmapped reads as zero
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_readdata <= 32'h0;
      end else if (i_read && o_waitrequest && wait_cnt == 2'h0) begin
         unique case (i_address)
            adc_seq_pkg::ADDR_CTRL: o_readdata <= {24'h0, ctrl};
            adc_seq_pkg::ADDR_STATUS:
               o_readdata <= {26'h0, first_done, o_osc_run, level};
            adc_seq_pkg::ADDR_COUNT: o_readdata <= {28'h0, fill};
            default: o_readdata <= 32'h0;
         endcase
      end
   end

   // configuration outputs
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_use_ext_ref <= 1'b0;
         o_differential <= 1'b0;
         o_ch_enable <= 2'h0;
      end else begin
         o_use_ext_ref <= ctrl[adc_seq_pkg::BIT_EXTREF];
         o_differential <= ctrl[adc_seq_pkg::BIT_DIFF];
         o_ch_enable <= {ctrl[adc_seq_pkg::BIT_CH1],
            ctrl[adc_seq_pkg::BIT_CH0]};
      end
   end

   // internal oscillator runs only during a single conversion
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         osc_cnt <= 2'h0;
      end else if (state == adc_seq_pkg::ST_IDLE) begin
         osc_cnt <= 2'h0;
      end else if (osc_cnt == 2'(OSC_CYCLES - 1)) begin
         osc_cnt <= 2'h0;
      end else begin
         osc_cnt <= osc_cnt + 2'h1;
      end
   end
   assign osc_tick = state == adc_seq_pkg::ST_CONV &&
      osc_cnt == 2'(OSC_CYCLES - 1);

   // single conversion: start holds both inputs at once, then the
   // oscillator feeds one channel per tick and runs on until the short
   // path is empty, so back to back starts overlap in the pipeline
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= adc_seq_pkg::ST_IDLE;
         ch_left <= 2'h0;
         o_hold <= 1'b0;
         o_osc_run <= 1'b0;
         held0 <= 12'h0;
         held1 <= 12'h0;
      end else begin
         o_osc_run <= state == adc_seq_pkg::ST_CONV;
         if (!single_mode) begin
            state <= adc_seq_pkg::ST_IDLE;
            ch_left <= 2'h0;
            o_hold <= 1'b0;
         end else if (start_fall && ch_left == 2'h0) begin
            state <= adc_seq_pkg::ST_CONV;
            o_hold <= 1'b1;
            held0 <= i_sample_ch0;
            held1 <= i_sample_ch1;
            ch_left <= two_ch ? 2'h2 : 2'h1;
         end else if (osc_tick) begin
            if (ch_left != 2'h0)
               ch_left <= ch_left - 2'h1;
            if (ch_left <= 2'h1)
               o_hold <= 1'b0;
            if (ch_left == 2'h0 && pipe_v[SGL_W-2:0] == '0)
               state <= adc_seq_pkg::ST_IDLE;
         end
      end
   end

   // conversion step source per mode, bubbles once the channels are in
   assign conv_step = single_mode ? osc_tick : cclk_fall;
   assign push_v = single_mode ? ch_left != 2'h0 : 1'b1;
   assign in_chan = single_mode ? (two_ch && ch_left == 2'h1) : 1'b0;
   assign in_data = !single_mode ? i_sample_ch0 : (in_chan ? held1 : held0);

   // pipeline: new sample enters while six older move on
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pipe_v <= '0;
         pipe_c <= '0;
         for (int i = 0; i < PIPE_W; i++)
            pipe_d[i] <= 12'h0;
      end else if (fifo_rst) begin
         pipe_v <= '0;
      end else if (conv_step) begin
         pipe_v <= {pipe_v[PIPE_W-2:0], push_v};
         pipe_c <= {pipe_c[PIPE_W-2:0], in_chan};
         pipe_d[0] <= in_data;
         for (int i = 1; i < PIPE_W; i++)
            pipe_d[i] <= pipe_d[i-1];
      end
   end

   // fifo write strobe: rising conv clock or oscillator tick
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wr_valid <= 1'b0;
         o_wr_data <= 12'h0;
         o_wr_channel <= 1'b0;
      end else begin
         if (single_mode) begin
            o_wr_valid <= osc_tick && pipe_v[SGL_W-1];
            o_wr_data <= pipe_d[SGL_W-1];
            o_wr_channel <= pipe_c[SGL_W-1];
         end else begin
            o_wr_valid <= cclk_rise && pipe_v[PIPE_W-1];
            o_wr_data <= pipe_d[PIPE_W-1];
            o_wr_channel <= pipe_c[PIPE_W-1];
         end
      end
   end

   // fill count toward trigger level, pulse active low on reach
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fill <= 4'h0;
         o_data_available_out_n <= 1'b1;
         first_done <= 1'b0;
      end else if (fifo_rst) begin
         fill <= 4'h0;
         o_data_available_out_n <= 1'b1;
         first_done <= 1'b0;
      end else begin
         o_data_available_out_n <= 1'b1;
         if (o_wr_valid) begin
            if (fill + 4'h1 >= level) begin
               fill <= 4'h0;
               o_data_available_out_n <= 1'b0;
               first_done <= 1'b1;
            end else begin
               fill <= fill + 4'h1;
            end
         end
      end
   end
endmodule // adc_conversion_sequencer

//--- bench/adc_seq_chk.sv
// port checker for the conversion sequencer
`timescale 1ns/1ps
module adc_seq_chk (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [1:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic o_waitrequest,
   input wire logic i_conversion_start_pulse,
   input wire logic o_hold,
   input wire logic o_data_available_out_n,
   input wire logic o_wr_valid,
   input wire logic o_use_ext_ref,
   input wire logic o_differential,
   input wire logic [1:0] o_ch_enable,
   input wire logic o_osc_run
);
   logic single_m;
   logic ctrl_wr;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // answered control write
   assign ctrl_wr = i_write && !o_waitrequest
      && i_address == adc_seq_pkg::ADDR_CTRL;
   // mode as last written, so starts only count in single mode
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         single_m <= 1'b1;
      else if (ctrl_wr)
         single_m <= i_writedata[adc_seq_pkg::BIT_SINGLE];
   end
   // request taken, and a start edge that must hold the inputs
   sequence s_taken;
      (i_read || i_write) && o_waitrequest;
   endsequence
   sequence s_start;
      single_m && (|o_ch_enable) && $fell(i_conversion_start_pulse);
   endsequence
   answer_next_a: assert property (s_taken |=> !o_waitrequest)
      else $error("no answer one cycle after request");
   answer_once_a: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("answer held longer than one cycle");
   answer_cause_a: assert property (
      !o_waitrequest |-> $past(i_read || i_write))
      else $error("answer without a request");
   dav_pulse_a: assert property (
      $fell(o_data_available_out_n) |=> o_data_available_out_n)
      else $error("data available low longer than one cycle");
   dav_cause_a: assert property (
      $fell(o_data_available_out_n) |-> $past(o_wr_valid))
      else $error("data available without a completing write");
   ctrl_mirror_a: assert property (
      ctrl_wr |-> ##2 {o_use_ext_ref, o_differential, o_ch_enable}
      == $past(i_writedata[7:4], 2))
      else $error("reference or input setting not applied");
   osc_hold_a: assert property ($rose(o_hold) |-> ##[0:2] o_osc_run)
      else $error("hold without the internal oscillator");
   hold_start_a: assert property (s_start |-> ##[1:8] o_hold)
      else $error("start edge did not hold the inputs");
endmodule // adc_seq_chk

bind adc_conversion_sequencer adc_seq_chk u_adc_seq_chk (.i_clk, .i_rst_n,
   .i_address, .i_read, .i_write, .i_writedata, .o_waitrequest,
   .i_conversion_start_pulse, .o_hold, .o_data_available_out_n, .o_wr_valid,
   .o_use_ext_ref, .o_differential, .o_ch_enable, .o_osc_run);

//--- bench/adc_host_model.sv
// host side: start pulses and the external conversion clock
`timescale 1ns/1ps
module adc_host_model (
   input wire logic i_clk,
   output logic o_start_n,
   output logic o_external_conversion_clock
);
   localparam int TC = adc_seq_pkg::OSC_CYC;
   // idle: start high, clock still low
   initial begin
      o_start_n = 1'b1;
      o_external_conversion_clock = 1'b0;
   end
   // one start at the shortest legal width and spacing plus slack
   task automatic pulse(input int nch, input int slack);
      int lo;
      int gap;
      lo = (nch == 2) ? (5 * TC + 1) / 2 : (3 * TC + 1) / 2;
      gap = (nch == 2) ? 3 * TC : 2 * TC;
      o_start_n <= 1'b0;
      repeat (lo) @(posedge i_clk);
      o_start_n <= 1'b1;
      // one extra clock high so the pin filter sees the release
      repeat (gap - lo + 1 + slack) @(posedge i_clk);
   endtask
   // n clock periods, slow enough for either channel count
   task automatic clocks(input int n, input int half);
      repeat (n) begin
         repeat (half) @(posedge i_clk);
         o_external_conversion_clock <= 1'b1;
         repeat (half) @(posedge i_clk);
         o_external_conversion_clock <= 1'b0;
      end
   endtask
endmodule // adc_host_model

//--- bench/adc_conversion_sequencer_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
   localparam int TCNS = adc_seq_pkg::OSC_CYC * adc_seq_pkg::CLK_NS;
   logic i_clk, i_rst_n, i_read, i_write, dav_q, ck_q;
   logic [1:0] i_address;
   logic [7:0] d;
   logic [31:0] i_writedata, o_readdata, q, seed;
   logic i_conversion_start_pulse, i_external_conversion_clock;
   logic [11:0] i_sample_ch0, i_sample_ch1, o_wr_data;
   logic o_waitrequest, o_hold, o_data_available_out_n, o_wr_valid;
   logic o_wr_channel, o_use_ext_ref, o_differential, o_osc_run;
   logic [1:0] o_ch_enable;
   int fails, checks, writes, davs, edges, edge_at;
   realtime t0, first_ns;
   int chq[$];
   logic [11:0] dq[$];
   logic hold_smp;
   adc_conversion_sequencer u_adc_conversion_sequencer (.*);
   adc_host_model u_host (.i_clk(i_clk), .o_start_n(i_conversion_start_pulse),
      .o_external_conversion_clock(i_external_conversion_clock));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic legal(input logic [3:0] l, input logic [2:0] s);
      if (s[1:0] == 2'b11)
         return l == (s[2] ? 4'h2 : 4'h1);
      if (s[2])
         return l inside {4'h2, 4'h4, 4'h8, 4'hC};
      return l inside {4'h1, 4'h4, 4'h8, 4'hE};
   endfunction
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [1:0] a,
      input logic [31:0] wd, output logic [31:0] r);
      int n;
      n = 0;
      i_address <= a;
      i_writedata <= wd;
      i_write <= wr;
      i_read <= !wr;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) fails++;
      r = o_readdata;
      i_write <= 1'b0;
      i_read <= 1'b0;
      @(posedge i_clk);
   endtask
   // single conversions: writes, pulses, scan order, first latency
   task automatic run_single(input int nch, input int np);
      int n;
      bus(1'b1, adc_seq_pkg::ADDR_CTRL, nch == 2 ? 32'h3F : 32'h1F, q);
      writes = 0;
      davs = 0;
      for (n = 0; n < np; n++) begin
         hold_smp <= 1'b0;
         @(posedge i_clk);
         hold_smp <= 1'b1;
         @(posedge i_clk);
         for (int c = 0; c < nch; c++) begin
            chq.push_back(c);
            dq.push_back(c ? i_sample_ch1 : i_sample_ch0);
         end
         if (n == 0) t0 = $realtime;
         u_host.pulse(nch, seed[29:28]);
      end
      for (n = 0; n < 300 && davs < np; n++) @(posedge i_clk);
      repeat (4) @(posedge i_clk);
      hold_smp <= 1'b0;
      check("unread data", dq.size(), 0);
      check("writes", writes, np * nch);
      check("pulses", davs, np);
      check("latency", first_ns <= (nch + 5.5) * TCNS + 15, 1);
      check("unwritten", chq.size(), 0);
   endtask
   // clock and fresh random samples every cycle while hold_smp is low
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      seed <= lfsr(seed);
      if (!hold_smp) begin
         i_sample_ch0 <= seed[11:0];
         i_sample_ch1 <= seed[27:16];
      end
   end
   // reference model: counts results and compares scan order
   always @(posedge i_clk) begin
      dav_q <= o_data_available_out_n;
      ck_q <= i_external_conversion_clock;
      if (i_external_conversion_clock === 1'b1 && ck_q === 1'b0) edges++;
      if (o_wr_valid === 1'b1) begin
         writes++;
         if (chq.size() > 0) check("channel", o_wr_channel, chq.pop_front());
         if (dq.size() > 0) check("data", o_wr_data, dq.pop_front());
      end
      if (o_data_available_out_n === 1'b0 && dav_q === 1'b1) begin
         if (davs == 0) begin
            first_ns = $realtime - adc_seq_pkg::CLK_NS - t0;
            edge_at = edges;
         end
         davs++;
      end
   end
   // watchdog
   initial begin
      repeat (5000) @(posedge i_clk);
      fails++;
      stop_test();
   end
   // main sequence
   initial begin
      seed = 32'h756A93B9;
      {i_rst_n, i_read, i_write, i_address, i_writedata} = '0;
      {i_sample_ch0, i_sample_ch1} = '0;
      hold_smp = 1'b0;
      repeat (8) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      bus(1'b0, adc_seq_pkg::ADDR_CTRL, 32'h0, q);
      check("ctrl reset", q, {24'h0, adc_seq_pkg::CTRL_RESET});
      bus(1'b0, 2'h3, 32'h0, q);
      check("unmapped", q, 32'h0);
      for (int s = 0; s < 8; s++) begin
         d = {seed[7:6], s[2] ? 2'b11 : 2'b01, s[1:0], 2'b10};
         bus(1'b1, adc_seq_pkg::ADDR_CTRL, {24'h0, d}, q);
         bus(1'b0, adc_seq_pkg::ADDR_CTRL, 32'h0, q);
         check("ctrl", q, {24'h0, d});
         bus(1'b0, adc_seq_pkg::ADDR_STATUS, 32'h0, q);
         check("level", legal(q[3:0], s[2:0]), 1);
      end
      run_single(1, 5);
      run_single(2, 4);
      bus(1'b1, adc_seq_pkg::ADDR_CTRL, 32'h1D, q);
      davs = 0;
      edges = 0;
      u_host.clocks(16, 4);
      repeat (12) @(posedge i_clk);
      check("first pulse edge", edge_at, 8);
      check("pulses", davs, 9);
      stop_test();
   end
endmodule // adc_conversion_sequencer_tb
